// ==== design/slp_pkg.sv ====
`default_nettype none
package slp_pkg;
  // register byte offsets
  localparam logic [7:0] SLP_OFF_MODE   = 8'h00;
  localparam logic [7:0] SLP_OFF_FRZ    = 8'h04;
  localparam logic [7:0] SLP_OFF_KEY_LO = 8'h08;
  localparam logic [7:0] SLP_OFF_KEY_HI = 8'h0c;
  localparam logic [7:0] SLP_OFF_UNL_LO = 8'h10;
  localparam logic [7:0] SLP_OFF_UNL_HI = 8'h14;
  localparam logic [7:0] SLP_OFF_CMD    = 8'h18;
  localparam logic [7:0] SLP_OFF_STAT   = 8'h1c;
  localparam logic [7:0] SLP_OFF_SEL    = 8'h20;
  localparam logic [7:0] SLP_OFF_PERS   = 8'h24;
  localparam logic [7:0] SLP_OFF_TEMP   = 8'h28;

  // field positions
  localparam int SLP_MODE_NP_BIT = 1;
  localparam int SLP_MODE_PW_BIT = 2;
  localparam int SLP_FRZ_BIT     = 0;
  localparam int SLP_TEMP_WP_BIT = 0;
  localparam int SLP_TEMP_LD_BIT = 1;
  localparam int SLP_STAT_BUSY   = 0;
  localparam int SLP_STAT_REF    = 1;
  localparam int SLP_STAT_CHK    = 2;

  // reset values
  localparam logic [15:0] SLP_MODE_RST   = 16'hffff;
  localparam logic        SLP_FRZ_RST    = 1'b1;
  localparam logic [63:0] SLP_KEY_RST    = 64'h0000_0000_0000_0000;
  localparam logic [31:0] SLP_PERS_OPEN  = 32'h0000_00ff;
  localparam logic [31:0] SLP_ZERO       = 32'h0000_0000;

  // commands written to the command register, and the word transfer size
  localparam logic [7:0] SLP_CMD_PROG  = 8'h01;
  localparam logic [7:0] SLP_CMD_ERASE = 8'h02;
  localparam logic [2:0] SLP_HSIZE_WORD = 3'h2;

  // sizes and timing
  localparam int SLP_NSEC          = 512;
  localparam int SLP_CLK_PERIOD_NS = 10;
  localparam int SLP_PROG_TIME_NS  = 10000;
  localparam int SLP_ERASE_TIME_NS = 100000;
  localparam int SLP_PROG_CYC  = (SLP_PROG_TIME_NS + SLP_CLK_PERIOD_NS - 1) / SLP_CLK_PERIOD_NS;
  localparam int SLP_ERASE_CYC = (SLP_ERASE_TIME_NS + SLP_CLK_PERIOD_NS - 1) / SLP_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROG,
    ST_ERASE
  } slp_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } slp_aph_t;
endpackage : slp_pkg
`default_nettype wire

// ==== design/slp_sector_lock.sv ====
`default_nettype none
module slp_sector_lock
  import slp_pkg::*;
#(
  parameter int NSEC      = SLP_NSEC,
  parameter int PROG_CYC  = SLP_PROG_CYC,
  parameter int ERASE_CYC = SLP_ERASE_CYC
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        NV_RST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic             BUSY_O
);

  localparam int SW = $clog2(NSEC);
  localparam int CW = $clog2(ERASE_CYC + 1);

  slp_aph_t        aph_q;
  slp_state_t      st_q;
  logic [15:0]     mode_q;
  logic [63:0]     key_q;
  logic [31:0]     unl_lo_q;
  logic            freeze_q;
  logic            init_q;
  logic            refused_q;
  logic            chk_q;
  logic [SW-1:0]   sel_q;
  logic [SW-1:0]   op_sec_q;
  logic [NSEC-1:0] plock_q;
  logic [NSEC-1:0] tlock_q;
  logic [NSEC-1:0] tdown_q;
  logic [CW-1:0]   cnt_q;
  logic            pw_mode;
  logic            cmd_go;
  logic            temp_go;
  logic            prog_go;
  logic            erase_go;
  logic            op_done;
  logic            unlock_ok;

  function automatic logic wr_hit(input slp_aph_t a, input logic [7:0] off);
    return a.valid && a.write && a.addr == off;
  endfunction : wr_hit

  assign pw_mode   = ~mode_q[SLP_MODE_PW_BIT];
  assign cmd_go    = wr_hit(aph_q, SLP_OFF_CMD);
  assign temp_go   = wr_hit(aph_q, SLP_OFF_TEMP);
  // freeze gates persistent commands in either mode; one operation at a time
  assign prog_go   = cmd_go && HWDATA_I[7:0] == SLP_CMD_PROG && st_q == ST_IDLE
                     && freeze_q;
  assign erase_go  = cmd_go && HWDATA_I[7:0] == SLP_CMD_ERASE && st_q == ST_IDLE
                     && freeze_q;
  assign op_done   = st_q != ST_IDLE && cnt_q == '0;
  assign unlock_ok = wr_hit(aph_q, SLP_OFF_UNL_HI) && pw_mode
                     && {HWDATA_I, unl_lo_q} == key_q;

  // address phase capture; the slave never stalls, so hready only follows us
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aph_q <= '0;
    end else if (HREADY_I) begin
      aph_q.valid <= HSEL_I && HTRANS_I[1] && HSIZE_I == SLP_HSIZE_WORD;
      aph_q.write <= HWRITE_I;
      aph_q.addr  <= HADDR_I[7:0];
    end
  end

  // mode bits only ever go from 1 to 0; a request clearing both is dropped
  always_ff @(posedge REF_CLK_I or posedge NV_RST_I) begin
    if (NV_RST_I) begin
      mode_q <= SLP_MODE_RST;
    end else if (wr_hit(aph_q, SLP_OFF_MODE)) begin
      if (!HWDATA_I[SLP_MODE_PW_BIT] && HWDATA_I[SLP_MODE_NP_BIT]
          && mode_q[SLP_MODE_NP_BIT]) begin
        mode_q[SLP_MODE_PW_BIT] <= 1'b0;
      end
      if (!HWDATA_I[SLP_MODE_NP_BIT] && HWDATA_I[SLP_MODE_PW_BIT]
          && mode_q[SLP_MODE_PW_BIT]) begin
        mode_q[SLP_MODE_NP_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge NV_RST_I) begin
    if (NV_RST_I) begin
      key_q <= SLP_KEY_RST;
    end else if (!pw_mode) begin
      if (wr_hit(aph_q, SLP_OFF_KEY_LO)) begin
        key_q[31:0] <= HWDATA_I;
      end
      if (wr_hit(aph_q, SLP_OFF_KEY_HI)) begin
        key_q[63:32] <= HWDATA_I;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      unl_lo_q <= SLP_ZERO;
    end else if (wr_hit(aph_q, SLP_OFF_UNL_LO)) begin
      unl_lo_q <= HWDATA_I;
    end
  end

  // the mode is only known after release, so the forced value lands one edge late
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      freeze_q <= SLP_FRZ_RST;
      init_q   <= 1'b1;
    end else begin
      init_q <= 1'b0;
      if (init_q) begin
        freeze_q <= ~pw_mode;
      end else if (unlock_ok) begin
        freeze_q <= 1'b1;
      end else if (wr_hit(aph_q, SLP_OFF_FRZ)) begin
        if (!HWDATA_I[SLP_FRZ_BIT]) begin
          freeze_q <= 1'b0;
        end else if (!pw_mode) begin
          freeze_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sel_q <= '0;
    end else if (wr_hit(aph_q, SLP_OFF_SEL)) begin
      sel_q <= HWDATA_I[SW-1:0];
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      refused_q <= 1'b0;
    end else if (cmd_go) begin
      refused_q <= !(prog_go || erase_go);
    end else if (temp_go) begin
      refused_q <= tdown_q[sel_q];
    end
  end

  // a reset during an operation abandons it; the persistent bits keep their value
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q     <= ST_IDLE;
      cnt_q    <= '0;
      op_sec_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (prog_go) begin
            st_q     <= ST_PROG;
            cnt_q    <= CW'(PROG_CYC - 1);
            op_sec_q <= sel_q;
          end else if (erase_go) begin
            st_q  <= ST_ERASE;
            cnt_q <= CW'(ERASE_CYC - 1);
          end
        end
        ST_PROG,
        ST_ERASE: begin
          if (cnt_q == '0) begin
            st_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge NV_RST_I) begin
    if (NV_RST_I) begin
      plock_q <= '1;
    end else if (op_done && st_q == ST_PROG) begin
      plock_q[op_sec_q] <= 1'b0;
    end else if (op_done && st_q == ST_ERASE) begin
      plock_q <= '1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tlock_q <= '0;
      tdown_q <= '0;
    end else if (temp_go && !tdown_q[sel_q]) begin
      tlock_q[sel_q] <= HWDATA_I[SLP_TEMP_WP_BIT];
      tdown_q[sel_q] <= HWDATA_I[SLP_TEMP_LD_BIT];
    end
  end

  // refusal of the selected sector, lags a selection change by one cycle
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      chk_q <= 1'b0;
    end else begin
      chk_q <= !plock_q[sel_q] || tlock_q[sel_q];
    end
  end

  // read data is registered at the address phase edge: zero wait states
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HRDATA_O <= SLP_ZERO;
    end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
      case (HADDR_I[7:0])
        SLP_OFF_MODE:   HRDATA_O <= {16'h0000, mode_q};
        SLP_OFF_FRZ:    HRDATA_O <= 32'(freeze_q);
        SLP_OFF_KEY_LO: HRDATA_O <= pw_mode ? SLP_ZERO : key_q[31:0];
        SLP_OFF_KEY_HI: HRDATA_O <= pw_mode ? SLP_ZERO : key_q[63:32];
        SLP_OFF_STAT:   HRDATA_O <= 32'({chk_q, refused_q, st_q != ST_IDLE});
        SLP_OFF_SEL:    HRDATA_O <= 32'(sel_q);
        SLP_OFF_PERS:   HRDATA_O <= plock_q[sel_q] ? SLP_PERS_OPEN : SLP_ZERO;
        SLP_OFF_TEMP:   HRDATA_O <= 32'({tdown_q[sel_q], tlock_q[sel_q]});
        default:        HRDATA_O <= SLP_ZERO;
      endcase
    end else begin
      HRDATA_O <= SLP_ZERO;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      BUSY_O      <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      BUSY_O      <= prog_go || erase_go || (st_q != ST_IDLE && !op_done);
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I || NV_RST_I);

  sequence s_prog_start;
    prog_go ##1 st_q == ST_PROG;
  endsequence

  sequence s_erase_end;
    st_q == ST_ERASE && cnt_q == '0;
  endsequence

  sequence s_cmd_frozen;
    cmd_go && !freeze_q && st_q == ST_IDLE;
  endsequence

  a_mode_excl: assert property (
    mode_q[SLP_MODE_PW_BIT] || mode_q[SLP_MODE_NP_BIT])
    else $error("both mode bits cleared");

  a_otp_sticky: assert property (
    !$past(mode_q[SLP_MODE_PW_BIT]) |-> !mode_q[SLP_MODE_PW_BIT])
    else $error("password mode bit returned to 1");

  a_np_keeps_pw: assert property (
    !mode_q[SLP_MODE_NP_BIT] |=> mode_q[SLP_MODE_PW_BIT])
    else $error("password mode entered after non-password mode");

  a_key_frozen: assert property (
    $past(pw_mode) |-> key_q == $past(key_q))
    else $error("key changed in password mode");

  a_frz_rise: assert property (
    $past(pw_mode) && $rose(freeze_q) |-> $past(unlock_ok))
    else $error("freeze set without key");

  a_unlock_set: assert property (
    unlock_ok && !init_q |=> freeze_q)
    else $error("unlock did not set freeze");

  a_frz_clear: assert property (
    wr_hit(aph_q, SLP_OFF_FRZ) && !HWDATA_I[SLP_FRZ_BIT] && !init_q && !unlock_ok
    |=> !freeze_q ##1 !freeze_q || $past(unlock_ok))
    else $error("freeze write of 0 ignored");

  a_reset_lock: assert property (
    $fell(init_q) && pw_mode |-> !freeze_q)
    else $error("freeze not forced after reset");

  a_prog_time: assert property (
    s_prog_start |-> ##[1:1000] !plock_q[op_sec_q])
    else $error("persistent program did not finish");

  a_erase_all: assert property (
    s_erase_end |=> &plock_q && st_q == ST_IDLE)
    else $error("persistent erase left a bit locked");

  a_frozen_refuse: assert property (
    s_cmd_frozen |=> refused_q && st_q == ST_IDLE && plock_q == $past(plock_q))
    else $error("persistent command taken while frozen");

  a_lockdown_hold: assert property (
    temp_go && tdown_q[sel_q] |=> tlock_q == $past(tlock_q) && tdown_q == $past(tdown_q))
    else $error("temporary bits changed under lock-down");

endmodule : slp_sector_lock
`default_nettype wire

// ==== tb/slp_host_model.sv ====
`default_nettype none
module slp_host_model (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic      [31:0] haddr_o,
  output logic      [1:0]  htrans_o,
  output logic             hwrite_o,
  output logic      [2:0]  hsize_o,
  output logic      [31:0] hwdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rd_dat;
  event        got;

  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0000_0000;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o  = 3'h0;
    hwdata_o = 32'h0000_0000;
    rd_dat   = 32'h0000_0000;
  end

  // one single transfer of the given size; the slave decides how long each phase lasts
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                      input logic [2:0] size);
    @(posedge clk_i);
    hsel_o   <= 1'b1;
    haddr_o  <= 32'(addr);
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    hsize_o  <= size;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_o   <= 1'b0;
    htrans_o <= 2'b00;
    haddr_o  <= ~32'(addr);
    hwdata_o <= data;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd_dat = hrdata_i;
    // a released data bus must not keep showing the last word
    hwdata_o <= ~data;
    if (!wr) -> got;
  endtask : xfer
endmodule : slp_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench
  import slp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 4;
  localparam int EC = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        nv_rst = 1'b1;
  logic        hsel, hwrite, hready, hresp, busy;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, key_lo, key_hi;
  logic [31:0] exp_q[$];
  int          n_fail = 0;
  int          checks_done = 0;

  always #5 clk = ~clk;

  slp_sector_lock #(.NSEC(512), .PROG_CYC(PC), .ERASE_CYC(EC)) dut (
    .REF_CLK_I(clk), .RST_I(rst), .NV_RST_I(nv_rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .BUSY_O(busy));

  slp_host_model host (
    .clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic stop_test;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, SLP_HSIZE_WORD);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 32'h0000_0000, SLP_HSIZE_WORD);
  endtask : rd

  // busy must rise and then fall exactly n edges after the command lands
  task automatic cmd(input logic [7:0] c, input int n);
    int i;
    wr(SLP_OFF_CMD, 32'(c));
    i = 0;
    do begin
      @(posedge clk);
      i++;
      #1;
      if (i == 1) chk(32'(busy), 32'h0000_0001);
    end while (busy === 1'b1 && i < 60);
    chk(i, n);
  endtask : cmd

  task automatic rst_pulse(input logic nv);
    @(posedge clk);
    rst    <= 1'b1;
    nv_rst <= nv;
    repeat (2) @(posedge clk);
    rst    <= 1'b0;
    nv_rst <= 1'b0;
  endtask : rst_pulse

  always @(host.got) begin
    chk(host.rd_dat, exp_q.size() ? exp_q.pop_front() : ~host.rd_dat);
    chk(32'(hresp), 32'h0000_0000);
    chk(32'(hready), 32'h0000_0001);
  end

  initial begin
    #50000;
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst    <= 1'b0;
    nv_rst <= 1'b0;
    rd(SLP_OFF_MODE, 32'h0000_ffff);
    rd(SLP_OFF_FRZ, 32'h0000_0001);
    rd(SLP_OFF_PERS, SLP_PERS_OPEN);
    rd(SLP_OFF_TEMP, SLP_ZERO);
    rd(8'h40, SLP_ZERO);
    key_lo = lfsr(32'h0000_0031);
    key_hi = lfsr(key_lo);
    wr(SLP_OFF_KEY_LO, key_lo);
    wr(SLP_OFF_KEY_HI, key_hi);
    rd(SLP_OFF_KEY_LO, key_lo);
    rd(SLP_OFF_KEY_HI, key_hi);
    wr(SLP_OFF_SEL, 32'h0000_0003);
    cmd(SLP_CMD_PROG, PC);
    rd(SLP_OFF_PERS, SLP_ZERO);
    rd(SLP_OFF_STAT, 32'h0000_0004);
    wr(SLP_OFF_FRZ, SLP_ZERO);
    rd(SLP_OFF_FRZ, SLP_ZERO);
    wr(SLP_OFF_CMD, 32'(SLP_CMD_ERASE));
    rd(SLP_OFF_STAT, 32'h0000_0006);
    rd(SLP_OFF_PERS, SLP_ZERO);
    wr(SLP_OFF_FRZ, 32'h0000_0001);
    cmd(SLP_CMD_ERASE, EC);
    rd(SLP_OFF_PERS, SLP_PERS_OPEN);
    // a byte sized write must leave the selection alone
    host.xfer(1'b1, SLP_OFF_SEL, 32'h0000_0005, 3'h0);
    rd(SLP_OFF_SEL, 32'h0000_0003);
    wr(SLP_OFF_SEL, 32'h0000_0005);
    wr(SLP_OFF_TEMP, 32'h0000_0001);
    rd(SLP_OFF_STAT, 32'h0000_0004);
    wr(SLP_OFF_TEMP, 32'h0000_0003);
    wr(SLP_OFF_TEMP, SLP_ZERO);
    rd(SLP_OFF_TEMP, 32'h0000_0003);
    rd(SLP_OFF_STAT, 32'h0000_0006);
    wr(SLP_OFF_MODE, 32'h0000_fffb);
    rd(SLP_OFF_MODE, 32'h0000_fffb);
    wr(SLP_OFF_MODE, 32'h0000_fffd);
    rd(SLP_OFF_MODE, 32'h0000_fffb);
    wr(SLP_OFF_KEY_LO, ~key_lo);
    rd(SLP_OFF_KEY_LO, SLP_ZERO);
    rst_pulse(1'b0);
    rd(SLP_OFF_FRZ, SLP_ZERO);
    wr(SLP_OFF_SEL, 32'h0000_0005);
    rd(SLP_OFF_TEMP, SLP_ZERO);
    wr(SLP_OFF_FRZ, 32'h0000_0001);
    rd(SLP_OFF_FRZ, SLP_ZERO);
    wr(SLP_OFF_UNL_LO, key_lo);
    wr(SLP_OFF_UNL_HI, ~key_hi);
    rd(SLP_OFF_FRZ, SLP_ZERO);
    wr(SLP_OFF_UNL_HI, key_hi);
    rd(SLP_OFF_FRZ, 32'h0000_0001);
    cmd(SLP_CMD_PROG, PC);
    rst_pulse(1'b0);
    wr(SLP_OFF_SEL, 32'h0000_0005);
    rd(SLP_OFF_PERS, SLP_ZERO);
    rst_pulse(1'b1);
    wr(SLP_OFF_MODE, 32'h0000_fffd);
    wr(SLP_OFF_MODE, 32'h0000_fffb);
    rd(SLP_OFF_MODE, 32'h0000_fffd);
    rd(SLP_OFF_FRZ, 32'h0000_0001);
    @(posedge clk);
    chk(exp_q.size(), 32'h0000_0000);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
